/* File: pkg/npe_pkg.sv */
// constants and types shared by the page ecc engine and its fifo
// assumes one 50 MHz clock for the whole engine
package npe_pkg;
    // ****************************************
    // page map
    // ****************************************
    localparam logic [11:0] NPE_SPARE_BASE = 12'h800;
    localparam logic [11:0] NPE_PAR_BASE = 12'h840;
    localparam logic [11:0] NPE_PAR_END = 12'h87F;
    localparam logic [9:0] NPE_SEG_BYTES = 10'h200;
    localparam logic [3:0] NPE_META_UNPROT = 4'h4;
    localparam logic [9:0] NPE_PROT_IDX_MAX = 10'h20B;
    localparam logic [5:0] NPE_PAR_CNT_LAST = 6'h3F;
    localparam logic [1:0] NPE_SEG_LAST = 2'h3;
    localparam logic [7:0] NPE_PAR_FILL = 8'hFF;
    // ****************************************
    // feature and status
    // ****************************************
    localparam logic [7:0] NPE_FEAT_WR_OP = 8'h1F;
    localparam logic NPE_ECC_EN_RST = 1'b1;
    localparam logic [1:0] NPE_STAT_OK = 2'h0;
    localparam logic [1:0] NPE_STAT_CORR = 2'h1;
    localparam logic [1:0] NPE_STAT_FAIL = 2'h2;
    // ****************************************
    // output fifo
    // ****************************************
    localparam int NPE_WORD_W = 21;
    localparam int NPE_FIFO_DEPTH = 32;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PAR, ST_FIX} npe_state_t;
endpackage

/* File: pkg/npe_fifo_if.sv */
// valid/ready carrier between the ecc engine and its output fifo
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface npe_fifo_if #(parameter int W = 21);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport src (output wr_valid, output wr_data, input wr_ready);
    modport fifo (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
    modport snk (input rd_valid, input rd_data, output rd_ready);
endinterface

/* File: logic/npe_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ns
module npe_fifo #(
    parameter int W = 21,
    parameter int D = 32
) (
    input wire logic i_clk,
    input wire logic i_rst,
    npe_fifo_if.fifo f
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign f.wr_ready = (cnt_ff != (AW+1)'(D));
    assign f.rd_valid = (cnt_ff != '0);
    assign f.rd_data = mem_ff[rp_ff];
    assign push = f.wr_valid & f.wr_ready;
    assign pop = f.rd_valid & f.rd_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wp_ff] <= f.wr_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= wp_ff + (AW)'(push);
            rp_ff <= rp_ff + (AW)'(pop);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // a full fifo must not move its write pointer, whatever the source offers
    property p_no_overflow;
        @(posedge i_clk) disable iff (i_rst)
            cnt_ff == (AW+1)'(D) |=> cnt_ff <= (AW+1)'(D) && wp_ff == $past(wp_ff);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo accepts when full");
    c_fifo_full: cover property (@(posedge i_clk) disable iff (i_rst) !f.wr_ready);
endmodule

/* File: logic/npe_ecc.sv */
// page ecc engine: parity on program, check and repair on read
// assumes all inputs come from logic on I_CLK; cache applies output words
//
// What this block does
// - ecc runs on page reads and programs when the enable bit is 1 and is bypassed when 0.
// - the enable bit is 1 after reset.
// - on program with ecc, parity is built over the 2k page before the array write.
// - on read with ecc, parity is rebuilt, compared to the stored one and single-bit errors fixed in cache.
// - with ecc, O_CACHE_OK rises after the last segment is checked, whether or not the fifo has drained to the cache.
// - after each checked read an ecc status tells success or failure.
// - with ecc, loads to 840H-87FH are dropped while reads still return stored parity.
// - each 16-byte spare segment has 4 unprotected then 12 protected bytes.
// - four 512-byte main segments each pair with a spare segment and a 16-byte parity block.
// - with ecc off every byte, parity area included, is programmable.
`timescale 1ns/1ns
module npe_ecc
    import npe_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_FEAT_WR,
    input wire logic [7:0] I_FEAT_OPCODE,
    input wire logic I_FEAT_ECC_EN,
    input wire logic I_CMD_START,
    input wire logic I_CMD_PROG,
    input wire logic I_IN_VALID,
    input wire logic I_IN_LAST,
    input wire logic [11:0] I_IN_ADDR,
    input wire logic [7:0] I_IN_DATA,
    output logic O_IN_READY,
    output logic O_OUT_VALID,
    output logic O_OUT_XOR,
    output logic [11:0] O_OUT_ADDR,
    output logic [7:0] O_OUT_DATA,
    input wire logic I_OUT_READY,
    output logic O_ECC_EN,
    output logic O_BUSY,
    output logic O_CACHE_OK,
    output logic O_ECC_DONE,
    output logic [1:0] O_ECC_STATUS
);
    npe_fifo_if #(.W(NPE_WORD_W)) f ();
    npe_state_t state_ff;
    logic ecc_en_ff, op_ecc_ff, op_prog_ff, cache_ok_ff, done_ff;
    logic [1:0] stat_ff, stat_acc_ff;
    logic [5:0] cnt_ff;
    logic [7:0] col_ff [4];
    logic [12:0] pos_ff [4];
    logic [7:0] st_col_ff [4];
    logic [12:0] st_pos_ff [4];
    logic in_main, in_meta, in_par, prot, drop, accept;
    logic [1:0] seg, fs;
    logic [9:0] idx, syn_idx;
    logic [7:0] syn_col, par_byte;
    logic [12:0] syn_pos;
    logic [31:0] col_all;
    logic fixable, clean, fix_step;
    logic [11:0] fix_addr;

    // one parity-weighted bit position per byte; locates a single flip
    function automatic logic [12:0] pos_term(input logic [9:0] ix, input logic [7:0] d);
        logic [2:0] b;
        logic p;
        b = '0;
        p = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (d[i]) begin
                b = b ^ 3'(i);
                p = ~p;
            end
        end
        return {p ? ix : 10'h000, b};
    endfunction

    // ****************************************
    // page map decode
    // ****************************************
    assign in_main = I_IN_ADDR < NPE_SPARE_BASE;
    assign in_meta = !in_main && I_IN_ADDR < NPE_PAR_BASE;
    assign in_par = I_IN_ADDR >= NPE_PAR_BASE && I_IN_ADDR <= NPE_PAR_END;
    assign seg = in_main ? I_IN_ADDR[10:9] : I_IN_ADDR[5:4];
    assign prot = in_main | (in_meta & (I_IN_ADDR[3:0] >= NPE_META_UNPROT));
    assign idx = in_main ? {1'b0, I_IN_ADDR[8:0]}
                         : NPE_SEG_BYTES + 10'(I_IN_ADDR[3:0] - NPE_META_UNPROT);
    assign drop = op_ecc_ff & op_prog_ff & in_par;
    assign O_IN_READY = (state_ff == ST_LOAD) & (f.wr_ready | drop);
    assign accept = I_IN_VALID & O_IN_READY;

    // ****************************************
    // repair decision for one segment
    // ****************************************
    assign fs = cnt_ff[1:0];
    assign syn_col = col_ff[fs] ^ st_col_ff[fs];
    assign syn_pos = pos_ff[fs] ^ st_pos_ff[fs];
    assign syn_idx = syn_pos[12:3];
    assign clean = (syn_col == 8'h00) && (syn_pos == 13'h0000);
    assign fixable = (syn_col == (8'h01 << syn_pos[2:0])) && (syn_idx <= NPE_PROT_IDX_MAX);
    assign fix_addr = (syn_idx < NPE_SEG_BYTES) ? {1'b0, fs, syn_idx[8:0]}
        : NPE_SPARE_BASE + {6'h00, fs, 4'h0} + 12'(syn_idx - NPE_SEG_BYTES)
          + 12'(NPE_META_UNPROT);
    assign fix_step = !fixable | f.wr_ready;

    always_comb begin
        case (cnt_ff[3:0])
            4'h0: par_byte = col_ff[cnt_ff[5:4]];
            4'h1: par_byte = pos_ff[cnt_ff[5:4]][7:0];
            4'h2: par_byte = {3'h0, pos_ff[cnt_ff[5:4]][12:8]};
            default: par_byte = NPE_PAR_FILL;
        endcase
    end

    // ****************************************
    // fifo feed
    // ****************************************
    always_comb begin
        case (state_ff)
            ST_LOAD: begin
                f.wr_valid = I_IN_VALID & !drop;
                f.wr_data = {1'b0, I_IN_ADDR, I_IN_DATA};
            end
            ST_PAR: begin
                f.wr_valid = 1'b1;
                f.wr_data = {1'b0, NPE_PAR_BASE + {6'h00, cnt_ff}, par_byte};
            end
            ST_FIX: begin
                f.wr_valid = fixable;
                f.wr_data = {1'b1, fix_addr, syn_col};
            end
            default: begin
                f.wr_valid = 1'b0;
                f.wr_data = '0;
            end
        endcase
    end

    npe_fifo #(.W(NPE_WORD_W), .D(NPE_FIFO_DEPTH)) u_fifo (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .f(f.fifo)
    );
    assign f.rd_ready = I_OUT_READY;
    assign O_OUT_VALID = f.rd_valid;
    assign {O_OUT_XOR, O_OUT_ADDR, O_OUT_DATA} = f.rd_data;

    // ****************************************
    // feature bit and command latch
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ecc_en_ff <= NPE_ECC_EN_RST;
        end else if (I_FEAT_WR && I_FEAT_OPCODE == NPE_FEAT_WR_OP) begin
            ecc_en_ff <= I_FEAT_ECC_EN;
        end
    end

    // sampled once per command so a feature write mid-page cannot split a page
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            op_ecc_ff <= NPE_ECC_EN_RST;
            op_prog_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && I_CMD_START) begin
            op_ecc_ff <= ecc_en_ff;
            op_prog_ff <= I_CMD_PROG;
        end
    end

    // ****************************************
    // sequence
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= '0;
                    if (I_CMD_START) begin
                        state_ff <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (accept && I_IN_LAST) begin
                        state_ff <= !op_ecc_ff ? ST_IDLE : (op_prog_ff ? ST_PAR : ST_FIX);
                    end
                end
                ST_PAR: begin
                    if (f.wr_ready) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (cnt_ff == NPE_PAR_CNT_LAST) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_FIX: begin
                    if (fix_step) begin
                        cnt_ff <= cnt_ff + 6'h01;
                        if (fs == NPE_SEG_LAST) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // parity accumulation
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int s = 0; s < 4; s++) begin
                col_ff[s] <= 8'h00;
                pos_ff[s] <= 13'h0000;
                st_col_ff[s] <= 8'h00;
                st_pos_ff[s] <= 13'h0000;
            end
        end else if (state_ff == ST_IDLE && I_CMD_START) begin
            for (int s = 0; s < 4; s++) begin
                col_ff[s] <= 8'h00;
                pos_ff[s] <= 13'h0000;
                st_col_ff[s] <= 8'h00;
                st_pos_ff[s] <= 13'h0000;
            end
        end else if (accept && op_ecc_ff) begin
            if (prot) begin
                col_ff[seg] <= col_ff[seg] ^ I_IN_DATA;
                pos_ff[seg] <= pos_ff[seg] ^ pos_term(idx, I_IN_DATA);
            end else if (in_par && !op_prog_ff) begin
                case (I_IN_ADDR[3:0])
                    4'h0: st_col_ff[seg] <= I_IN_DATA;
                    4'h1: st_pos_ff[seg][7:0] <= I_IN_DATA;
                    4'h2: st_pos_ff[seg][12:8] <= I_IN_DATA[4:0];
                    default: st_col_ff[seg] <= st_col_ff[seg];
                endcase
            end
        end
    end

    // ****************************************
    // status
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            stat_acc_ff <= NPE_STAT_OK;
            stat_ff <= NPE_STAT_OK;
            done_ff <= 1'b0;
            cache_ok_ff <= 1'b1;
        end else begin
            done_ff <= 1'b0;
            if (state_ff == ST_IDLE && I_CMD_START) begin
                stat_acc_ff <= NPE_STAT_OK;
                if (!I_CMD_PROG) begin
                    cache_ok_ff <= 1'b0;
                end
            end else if (state_ff == ST_LOAD && accept && I_IN_LAST && !op_ecc_ff) begin
                cache_ok_ff <= 1'b1;
            end else if (state_ff == ST_FIX && fix_step) begin
                if (!clean && !fixable) begin
                    stat_acc_ff <= NPE_STAT_FAIL;
                end else if (fixable && stat_acc_ff != NPE_STAT_FAIL) begin
                    stat_acc_ff <= NPE_STAT_CORR;
                end
                if (fs == NPE_SEG_LAST) begin
                    done_ff <= 1'b1;
                    cache_ok_ff <= 1'b1;
                    if (!clean && !fixable) begin
                        stat_ff <= NPE_STAT_FAIL;
                    end else if (fixable && stat_acc_ff != NPE_STAT_FAIL) begin
                        stat_ff <= NPE_STAT_CORR;
                    end else begin
                        stat_ff <= stat_acc_ff;
                    end
                end
            end
        end
    end

    assign O_ECC_EN = ecc_en_ff;
    assign O_BUSY = (state_ff != ST_IDLE);
    assign O_CACHE_OK = cache_ok_ff;
    assign O_ECC_DONE = done_ff;
    assign O_ECC_STATUS = stat_ff;

    // ****************************************
    // checks
    // ****************************************
    property p_rst_en;
        @(posedge I_CLK) disable iff (I_RST) $past(I_RST) |-> ecc_en_ff;
    endproperty
    a_rst_en: assert property (p_rst_en) else $error("ecc not enabled after reset");
    property p_latch;
        @(posedge I_CLK) disable iff (I_RST)
            state_ff == ST_IDLE && I_CMD_START |=> op_ecc_ff == $past(ecc_en_ff);
    endproperty
    a_latch: assert property (p_latch) else $error("command missed the enable bit");
    property p_bypass;
        @(posedge I_CLK) disable iff (I_RST)
            state_ff == ST_PAR || state_ff == ST_FIX |-> op_ecc_ff;
    endproperty
    a_bypass: assert property (p_bypass) else $error("ecc phase with ecc off");
    property p_drop;
        @(posedge I_CLK) disable iff (I_RST)
            accept && op_ecc_ff && op_prog_ff && in_par |-> !f.wr_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("parity area load passed");
    property p_prog_par;
        @(posedge I_CLK) disable iff (I_RST)
            accept && I_IN_LAST && op_ecc_ff && op_prog_ff |=> state_ff == ST_PAR [*2];
    endproperty
    a_prog_par: assert property (p_prog_par) else $error("no parity after load");
    property p_par_end;
        @(posedge I_CLK) disable iff (I_RST)
            state_ff == ST_PAR && cnt_ff == NPE_PAR_CNT_LAST && f.wr_ready
            |=> state_ff == ST_IDLE;
    endproperty
    a_par_end: assert property (p_par_end) else $error("parity count wrong");
    property p_gate;
        @(posedge I_CLK) disable iff (I_RST) state_ff == ST_FIX |-> !O_CACHE_OK;
    endproperty
    a_gate: assert property (p_gate) else $error("cache open before repair");
    property p_done;
        @(posedge I_CLK) disable iff (I_RST)
            state_ff == ST_FIX && fs == NPE_SEG_LAST && fix_step |=> O_ECC_DONE && O_CACHE_OK;
    endproperty
    a_done: assert property (p_done) else $error("status not reported");
    // a stalled repair word must wait in place, not be skipped
    property p_fix;
        @(posedge I_CLK) disable iff (I_RST)
            state_ff == ST_FIX && fixable && !f.wr_ready
            |=> state_ff == ST_FIX && f.wr_valid && f.wr_data[20];
    endproperty
    a_fix: assert property (p_fix) else $error("repair word missing");
    assign col_all = {col_ff[3], col_ff[2], col_ff[1], col_ff[0]};
    property p_unprot;
        @(posedge I_CLK) disable iff (I_RST)
            accept && in_meta && I_IN_ADDR[3:0] < NPE_META_UNPROT |=> $stable(col_all);
    endproperty
    a_unprot: assert property (p_unprot) else $error("unprotected byte in parity");
    c_prog: cover property (@(posedge I_CLK) disable iff (I_RST) state_ff == ST_PAR);
    c_corr: cover property (@(posedge I_CLK) disable iff (I_RST)
        O_ECC_DONE && O_ECC_STATUS == NPE_STAT_CORR);
    c_fail: cover property (@(posedge I_CLK) disable iff (I_RST)
        O_ECC_DONE && O_ECC_STATUS == NPE_STAT_FAIL);
endmodule

/* File: tb/npe_cache_model.sv */
// cache side model: takes output words of the ecc engine and applies them
// assumes words arrive on the engine clock, valid/ready style
`timescale 1ns/1ns
module npe_cache_model (
    input wire logic i_clk,
    input wire logic i_hold,
    input wire logic i_valid,
    input wire logic i_xor,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_ready
);
    logic [7:0] mem [0:2175];
    initial begin
        o_ready = 1'b0;
    end
    // random stalls so the fifo really sees back pressure
    always @(negedge i_clk) begin
        o_ready <= !i_hold && ($urandom_range(3) != 0);
    end
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            mem[i_addr] <= i_xor ? (mem[i_addr] ^ i_data) : i_data;
        end
    end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the page ecc engine
// assumes npe_ecc with its fifo inside; the cache model consumes output words
`timescale 1ns/1ns
module tb_top;
    import npe_pkg::*;
    logic clk, rst, feat_wr, feat_en, cmd_start, cmd_prog, in_valid, in_last;
    logic [7:0] feat_op, in_data, out_data;
    logic [11:0] in_addr, out_addr;
    logic in_ready, out_valid, out_xor, out_ready, ecc_en, busy, cache_ok, ecc_done;
    logic [1:0] ecc_status;
    logic hold, saw_full;
    logic [7:0] pg [0:2175];
    logic [20:0] exp_w [$];
    logic [1:0] exp_s [$];
    int bad_count, n_checks, cyc;
    // error table: none, one main bit, one spare bit, two bits in one segment
    logic [11:0] fa [4] = '{12'hFFF, 12'h2A5, 12'h826, 12'h105};
    logic [7:0] fm [4] = '{8'h00, 8'h08, 8'h80, 8'h01};
    logic [11:0] fb [4] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'h110};
    logic [7:0] fn [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
    logic [1:0] es [4] = '{NPE_STAT_OK, NPE_STAT_CORR, NPE_STAT_CORR, NPE_STAT_FAIL};

    npe_ecc dut (.I_CLK(clk), .I_RST(rst), .I_FEAT_WR(feat_wr), .I_FEAT_OPCODE(feat_op),
        .I_FEAT_ECC_EN(feat_en), .I_CMD_START(cmd_start), .I_CMD_PROG(cmd_prog),
        .I_IN_VALID(in_valid), .I_IN_LAST(in_last), .I_IN_ADDR(in_addr),
        .I_IN_DATA(in_data), .O_IN_READY(in_ready), .O_OUT_VALID(out_valid),
        .O_OUT_XOR(out_xor), .O_OUT_ADDR(out_addr), .O_OUT_DATA(out_data),
        .I_OUT_READY(out_ready), .O_ECC_EN(ecc_en), .O_BUSY(busy), .O_CACHE_OK(cache_ok),
        .O_ECC_DONE(ecc_done), .O_ECC_STATUS(ecc_status));
    npe_cache_model cache (.i_clk(clk), .i_hold(hold), .i_valid(out_valid),
        .i_xor(out_xor), .i_addr(out_addr), .i_data(out_data), .o_ready(out_ready));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk_flag(input string what, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic chk_word(input logic [20:0] e, input logic [20:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value out word expected %h seen %h", e, s);
        end
    endtask
    task automatic chk_stat(input logic [1:0] e, input logic [1:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value ecc status expected %h seen %h", e, s);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // result watcher and timeout
    // ****************************************
    always @(posedge clk) begin
        cyc++;
        if (!rst && in_valid && in_ready !== 1'b1 && hold) begin
            saw_full <= 1'b1;
        end
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_w.size() == 0) begin
                chk_flag("word allowed", 1'b0, 1'b1);
            end else begin
                chk_word(exp_w.pop_front(), {out_xor, out_addr, out_data});
            end
        end
        if (!rst && ecc_done === 1'b1) begin
            if (exp_s.size() == 0) begin
                chk_flag("done allowed", 1'b0, 1'b1);
            end else begin
                chk_stat(exp_s.pop_front(), ecc_status);
            end
        end
        if (cyc == 60000) begin
            bad_count++;
            print_verdict;
        end
    end
    // ****************************************
    // stimulus
    // ****************************************
    task automatic feat(input logic [7:0] op, input logic en);
        @(negedge clk);
        feat_wr = 1'b1;
        feat_op = op;
        feat_en = en;
        @(negedge clk);
        feat_wr = 1'b0;
    endtask
    // called at a falling edge, returns at the one after acceptance
    task automatic put(input logic [11:0] a, input logic [7:0] d, input logic l);
        in_valid = 1'b1;
        in_addr = a;
        in_data = d;
        in_last = l;
        @(posedge clk);
        while (in_ready !== 1'b1) @(posedge clk);
        @(negedge clk);
    endtask
    // parity per segment: column xor, then xor of {index, bit} of each set bit
    task automatic calc_par;
        logic [7:0] col;
        logic [12:0] pos;
        int a;
        for (int s = 0; s < 4; s++) begin
            col = 8'h00;
            pos = 13'h0000;
            for (int x = 0; x < 524; x++) begin
                a = (x < 512) ? s * 512 + x : 2048 + s * 16 + x - 508;
                col ^= pg[a];
                for (int b = 0; b < 8; b++) if (pg[a][b]) pos ^= {x[9:0], b[2:0]};
            end
            pg[2112 + s * 16] = col;
            pg[2113 + s * 16] = pos[7:0];
            pg[2114 + s * 16] = {3'b000, pos[12:8]};
            for (int j = 3; j < 16; j++) pg[2112 + s * 16 + j] = NPE_PAR_FILL;
        end
    endtask
    task automatic page(input logic prog, input logic ecc, input int k);
        int top;
        logic [7:0] d;
        top = (ecc && prog) ? 2111 : 2175;
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_prog = prog;
        @(negedge clk);
        cmd_start = 1'b0;
        chk_flag("busy", 1'b1, busy);
        if (!prog) chk_flag("cache_ok low", 1'b0, cache_ok);
        // parity area loads go in first and must vanish
        if (ecc && prog) for (int i = 0; i < 4; i++) put(12'h840 + i[11:0], 8'h5A, 1'b0);
        for (int i = 0; i <= top; i++) begin
            d = pg[i] ^ (i[11:0] == fa[k] ? fm[k] : 8'h00) ^ (i[11:0] == fb[k] ? fn[k] : 8'h00);
            exp_w.push_back({1'b0, i[11:0], d});
            put(i[11:0], d, i == top);
        end
        in_valid = 1'b0;
        in_last = 1'b0;
        if (ecc && prog) begin
            for (int j = 0; j < 64; j++) begin
                exp_w.push_back({1'b0, 12'h840 + j[11:0], pg[2112 + j]});
            end
        end
        if (ecc && !prog && es[k] == NPE_STAT_CORR) exp_w.push_back({1'b1, fa[k], fm[k]});
        if (ecc && !prog) exp_s.push_back(es[k]);
        for (int t = 0; t < 600 && (busy !== 1'b0 || exp_w.size() != 0); t++) @(negedge clk);
        chk_flag("idle", 1'b0, busy);
        chk_flag("fifo empty", 1'b0, out_valid);
        chk_flag("cache_ok high", 1'b1, cache_ok);
        // the cache must hold the repaired byte only where ecc could fix it
        if (!prog && fa[k] != 12'hFFF) begin
            d = pg[fa[k]] ^ ((ecc && es[k] == NPE_STAT_CORR) ? 8'h00 : fm[k]);
            chk_word({13'h0000, d}, {13'h0000, cache.mem[fa[k]]});
        end
    endtask
    initial begin
        {rst, feat_wr, feat_en, cmd_start, cmd_prog, in_valid, in_last} = 7'h40;
        {feat_op, in_data, in_addr} = 28'h0000000;
        {hold, saw_full, bad_count, n_checks, cyc} = '0;
        void'($urandom(43371));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk_flag("ecc_en reset", 1'b1, ecc_en);
        chk_flag("cache_ok reset", 1'b1, cache_ok);
        chk_stat(NPE_STAT_OK, ecc_status);
        $display("test reset done");
        for (int i = 0; i < 2176; i++) pg[i] = 8'($urandom_range(255));
        pg[2048] = 8'hFF;
        calc_par;
        hold = 1'b1;
        fork
            begin
                repeat (90) @(negedge clk);
                hold = 1'b0;
            end
        join_none
        page(1'b1, 1'b1, 0);
        chk_flag("fifo full refused", 1'b1, saw_full);
        $display("test program ecc done");
        for (int k = 0; k < 4; k++) page(1'b0, 1'b1, k);
        $display("test read ecc done");
        feat(8'h0F, 1'b0);
        chk_flag("ecc_en other opcode", 1'b1, ecc_en);
        feat(NPE_FEAT_WR_OP, 1'b0);
        chk_flag("ecc_en off", 1'b0, ecc_en);
        for (int i = 0; i < 2176; i++) pg[i] = 8'($urandom_range(255));
        page(1'b1, 1'b0, 0);
        page(1'b0, 1'b0, 1);
        chk_stat(NPE_STAT_FAIL, ecc_status);
        feat(NPE_FEAT_WR_OP, 1'b1);
        chk_flag("ecc_en on", 1'b1, ecc_en);
        chk_flag("no results left", 1'b1, exp_w.size() == 0 && exp_s.size() == 0);
        $display("test ecc off done");
        print_verdict;
    end
endmodule
